// *** rtl/scpt_pkg.sv ***
package scpt_pkg;
	localparam int SCPT_INSTR_BITS = 16;
	localparam int SCPT_ADDR_BITS = 13;
	localparam int SCPT_RW_POS = 15;
	localparam int SCPT_LEN_HI_POS = 14;
	localparam int SCPT_LEN_LO_POS = 13;
	localparam logic [12:0] SCPT_ADDR_FIRST = 13'h0000;
	localparam logic [12:0] SCPT_ADDR_LAST = 13'h0034;
	localparam logic [12:0] SCPT_OFS_PORT_CFG = 13'h0000;
	localparam logic [12:0] SCPT_OFS_READBACK = 13'h0004;
	localparam logic [12:0] SCPT_OFS_UPDATE = 13'h0005;
	localparam logic [12:0] SCPT_OFS_PUMP = 13'h000a;
	localparam logic [7:0] SCPT_RST_PORT_CFG = 8'h18;
	localparam logic [7:0] SCPT_RST_READBACK = 8'h00;
	localparam logic [7:0] SCPT_RST_UPDATE = 8'h00;
	localparam logic [7:0] SCPT_RST_PUMP = 8'h80;
	localparam int SCPT_CFG_LSB_HI_POS = 6;
	localparam int SCPT_CFG_SRST_HI_POS = 5;
	localparam int SCPT_CFG_SRST_LO_POS = 2;
	localparam int SCPT_CFG_LSB_LO_POS = 1;
	localparam logic [7:0] SCPT_CFG_FIXED_MASK = 8'h18;
	localparam logic [7:0] SCPT_CFG_WR_MASK = 8'h66;
	localparam int SCPT_READBACK_POS = 0;
	localparam int SCPT_UPDATE_POS = 0;
	localparam logic [1:0] SCPT_LEN_STREAM = 2'h3;
endpackage

// *** rtl/scpt_port.sv ***
`timescale 1ns/100ps
// Behaviour
// - read with length 0,1,2 shifts out 1, 2 or 3 bytes
// - read length 3 streams bytes until chip select rises
// - read bits stable for controller to take on rising sclk edge
// - read data driven on the same bidirectional data pin
// - readback bit set returns buffered values, else active values
// - only 16-bit instructions; map spans 0x00 to 0x34
// - instruction: rw top bit, two length bits, 13-bit address
// - instruction address is first data byte address
// - msb first default; lsb first after bit 6 of 0x00 plus update
// - lsb first order applies from the next frame, once chip select is idle
// - msb first order decrements address per byte
// - lsb first order increments address per byte
// - address walk visits every address, no skipping
// - self-clearing bits return to zero after their task
// - writes to 0x00, 0x04 and 0x0a land in shadow registers, copied to active on update
// - writing bit 0 of 0x05 copies all shadows at once
// - capture on rising sclk, change read data on falling sclk
// - data pin undriven while chip select high
module scpt_port
	import scpt_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdio_i,
	output logic sdio_o,
	output logic sdio_oe_n,
	output logic lsb_first,
	output logic [7:0] pump_current,
	output logic soft_reset_pulse,
	output logic busy
);
	// ---------------- link side, sclk domain ----------------
	typedef enum logic [1:0] {SCPT_INSTR, SCPT_WDATA, SCPT_RDATA} scpt_state_e;
	scpt_state_e state_q;
	logic [3:0] bit_cnt_q;
	logic [15:0] shift_q;
	logic rw_q;
	logic [1:0] len_q;
	logic [1:0] byte_cnt_q;
	logic [12:0] addr_q;
	logic [7:0] rd_shift_q;
	logic [7:0] rd_byte;
	logic sclk_lsb;
	logic [15:0] instr_word;
	logic [7:0] wr_byte;
	logic [15:0] shift_in;
	logic [12:0] addr_next;
	// write event handshake to clk domain
	logic wr_tog_q;
	logic [12:0] wr_addr_q;
	logic [7:0] wr_data_q;
	logic [7:0] rd_dbyte;
	logic [7:0] snap_q [0:3];

	// lsb order comes from a level held steady in the core domain between updates
	assign sclk_lsb = lsb_first;

	always_comb begin
		shift_in = {shift_q[14:0], sdio_i};
	end

	// lsb first: bits arrive reversed, so flip the assembled word
	always_comb begin
		instr_word = shift_in;
		wr_byte = shift_in[7:0];
		if (sclk_lsb) begin
			for (int i = 0; i < SCPT_INSTR_BITS; i++) begin
				instr_word[i] = shift_in[SCPT_INSTR_BITS - 1 - i];
			end
			for (int i = 0; i < 8; i++) begin
				wr_byte[i] = shift_in[7 - i];
			end
		end
	end

	assign addr_next = sclk_lsb ? addr_q + 13'h0001 : addr_q - 13'h0001;

	// cs_n acts as an asynchronous restart of the link logic
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			state_q <= SCPT_INSTR;
			bit_cnt_q <= 4'h0;
			shift_q <= 16'h0000;
			rw_q <= 1'b0;
			len_q <= 2'h0;
			byte_cnt_q <= 2'h0;
			addr_q <= 13'h0000;
			wr_tog_q <= 1'b0;
			wr_addr_q <= 13'h0000;
			wr_data_q <= 8'h00;
		end else begin
			shift_q <= shift_in;
			bit_cnt_q <= bit_cnt_q + 4'h1;
			case (state_q)
				SCPT_INSTR: begin
					if (bit_cnt_q == 4'hf) begin
						bit_cnt_q <= 4'h0;
						rw_q <= instr_word[SCPT_RW_POS];
						len_q <= {instr_word[SCPT_LEN_HI_POS], instr_word[SCPT_LEN_LO_POS]};
						addr_q <= instr_word[SCPT_ADDR_BITS-1:0];
						byte_cnt_q <= 2'h0;
						state_q <= instr_word[SCPT_RW_POS] ? SCPT_RDATA : SCPT_WDATA;
					end
				end
				SCPT_WDATA, SCPT_RDATA: begin
					if (bit_cnt_q[2:0] == 3'h7) begin
						bit_cnt_q <= 4'h0;
						if (state_q == SCPT_WDATA) begin
							wr_addr_q <= addr_q;
							wr_data_q <= wr_byte;
							wr_tog_q <= ~wr_tog_q;
						end
						addr_q <= addr_next;
						if (len_q != SCPT_LEN_STREAM) begin
							byte_cnt_q <= byte_cnt_q + 2'h1;
							if (byte_cnt_q == len_q) begin
								state_q <= SCPT_INSTR;
							end
						end
					end
				end
				default: state_q <= SCPT_INSTR;
			endcase
		end
	end

	// read byte picked from a core-domain snapshot stable while cs_n is low
	always_comb begin
		rd_dbyte = 8'h00;
		if (addr_q == SCPT_OFS_PORT_CFG) begin
			rd_dbyte = snap_q[0];
		end else if (addr_q == SCPT_OFS_READBACK) begin
			rd_dbyte = snap_q[1];
		end else if (addr_q == SCPT_OFS_UPDATE) begin
			rd_dbyte = snap_q[2];
		end else if (addr_q == SCPT_OFS_PUMP) begin
			rd_dbyte = snap_q[3];
		end
		rd_byte = rd_dbyte;
	end

	// read data launched on falling sclk so it is stable at the next rise
	logic rd_active;
	logic rd_load;
	assign rd_active = (state_q == SCPT_RDATA);
	assign rd_load = rd_active && (bit_cnt_q[2:0] == 3'h0);

	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			rd_shift_q <= 8'h00;
			sdio_o <= 1'b0;
			sdio_oe_n <= 1'b1;
		end else begin
			sdio_oe_n <= ~rd_active;
			if (rd_load) begin
				sdio_o <= sclk_lsb ? rd_byte[0] : rd_byte[7];
				rd_shift_q <= sclk_lsb ? {1'b0, rd_byte[7:1]} : {rd_byte[6:0], 1'b0};
			end else if (rd_active) begin
				sdio_o <= sclk_lsb ? rd_shift_q[0] : rd_shift_q[7];
				rd_shift_q <= sclk_lsb ? {1'b0, rd_shift_q[7:1]} : {rd_shift_q[6:0], 1'b0};
			end
		end
	end

	// ---------------- core side, clk domain ----------------
	logic cs_n_s;
	logic cs_act_s;
	logic wr_tog_s;
	logic wr_tog_d_q;
	logic wr_evt;
	logic [7:0] cfg_sh_q, rb_sh_q, pump_sh_q;
	logic [7:0] cfg_act_q, rb_act_q, pump_act_q;
	logic [7:0] upd_q;
	logic do_update;

	// select is synchronised as an active-high level so that its reset value
	// matches the idle pin and no false busy or frame start follows reset
	scpt_sync2 u_cs_sync (
		.clk(clk),
		.resetn(resetn),
		.d(~cs_n),
		.q(cs_act_s)
	);
	assign cs_n_s = ~cs_act_s;

	scpt_sync2 u_wr_sync (
		.clk(clk),
		.resetn(resetn),
		.d(wr_tog_q),
		.q(wr_tog_s)
	);

	// toggle resets low at each cs rise, so track it through cs idle
	always_ff @(posedge clk) begin
		if (!resetn) begin
			wr_tog_d_q <= 1'b0;
		end else if (clk_en) begin
			wr_tog_d_q <= wr_tog_s;
		end
	end
	// a low-going toggle from the cs-rise clear is no write
	assign wr_evt = clk_en && (wr_tog_s != wr_tog_d_q) && !(cs_n_s && !wr_tog_s);

	assign do_update = upd_q[SCPT_UPDATE_POS];

	// shadow registers
	always_ff @(posedge clk) begin
		if (!resetn || soft_reset_pulse) begin
			cfg_sh_q <= SCPT_RST_PORT_CFG;
			rb_sh_q <= SCPT_RST_READBACK;
			pump_sh_q <= SCPT_RST_PUMP;
		end else if (wr_evt) begin
			if (wr_addr_q == SCPT_OFS_PORT_CFG) begin
				cfg_sh_q <= (wr_data_q & SCPT_CFG_WR_MASK) | SCPT_CFG_FIXED_MASK;
			end else if (wr_addr_q == SCPT_OFS_READBACK) begin
				rb_sh_q <= {7'h00, wr_data_q[SCPT_READBACK_POS]};
			end else if (wr_addr_q == SCPT_OFS_PUMP) begin
				pump_sh_q <= wr_data_q;
			end
		end
	end

	// update trigger, self clearing on the same edge as its copy
	always_ff @(posedge clk) begin
		if (!resetn || soft_reset_pulse) begin
			upd_q <= SCPT_RST_UPDATE;
		end else if (clk_en) begin
			if (wr_evt && wr_addr_q == SCPT_OFS_UPDATE) begin
				upd_q <= {7'h00, wr_data_q[SCPT_UPDATE_POS]};
			end else begin
				upd_q <= SCPT_RST_UPDATE;
			end
		end
	end

	// active registers, all copied in one edge
	always_ff @(posedge clk) begin
		if (!resetn || soft_reset_pulse) begin
			cfg_act_q <= SCPT_RST_PORT_CFG;
			rb_act_q <= SCPT_RST_READBACK;
			pump_act_q <= SCPT_RST_PUMP;
		end else if (clk_en && do_update) begin
			cfg_act_q <= cfg_sh_q;
			rb_act_q <= rb_sh_q;
			pump_act_q <= pump_sh_q;
		end
	end

	// soft reset is self clearing: one pulse then back to defaults
	always_ff @(posedge clk) begin
		if (!resetn) begin
			soft_reset_pulse <= 1'b0;
		end else if (clk_en) begin
			soft_reset_pulse <= !soft_reset_pulse &&
				(cfg_act_q[SCPT_CFG_SRST_HI_POS] || cfg_act_q[SCPT_CFG_SRST_LO_POS]);
		end
	end

	// lsb order held; changes only while the link is idle
	always_ff @(posedge clk) begin
		if (!resetn) begin
			lsb_first <= 1'b0;
		end else if (clk_en && cs_n_s) begin
			lsb_first <= cfg_act_q[SCPT_CFG_LSB_HI_POS] | cfg_act_q[SCPT_CFG_LSB_LO_POS];
		end
	end

	// readback snapshot, frozen while a cycle is in progress
	always_ff @(posedge clk) begin
		if (!resetn) begin
			for (int i = 0; i < 4; i++) begin
				snap_q[i] <= 8'h00;
			end
		end else if (clk_en && cs_n_s) begin
			snap_q[0] <= rb_act_q[SCPT_READBACK_POS] ? cfg_sh_q : cfg_act_q;
			snap_q[1] <= rb_act_q[SCPT_READBACK_POS] ? rb_sh_q : rb_act_q;
			snap_q[2] <= upd_q;
			snap_q[3] <= rb_act_q[SCPT_READBACK_POS] ? pump_sh_q : pump_act_q;
		end
	end

	assign pump_current = pump_act_q;
	assign busy = cs_act_s;
endmodule // scpt_port

// *** rtl/scpt_sync2.sv ***
`timescale 1ns/100ps
// two-stage level synchroniser
module scpt_sync2 (
	input wire logic clk,
	input wire logic resetn,
	input wire logic d,
	output logic q
);
	logic meta_q;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			meta_q <= 1'b0;
			q <= 1'b0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule // scpt_sync2

// *** test/scpt_host.sv ***
`timescale 1ns/100ps
module scpt_host (
	output logic sclk,
	output logic cs_n,
	output logic sdio_i,
	input wire logic sdio_o,
	input wire logic sdio_oe_n
);
	logic hd_q;
	assign sdio_i = sdio_oe_n ? hd_q : sdio_o;
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		hd_q = 1'b0;
	end
	// byte b of wd and rd sits at [31-8*b -: 8]
	task automatic xfer(input logic [15:0] ins, input logic [31:0] wd, input int n,
		input bit lsb, output logic [31:0] rd);
		int x;
		rd = 32'h0000_0000;
		cs_n = 1'b0;
		for (int i = 0; i < 16 + 8 * n; i++) begin
			x = lsb ? 24 - 8 * (i / 8 - 2) + i % 8 : 31 - 8 * (i / 8 - 2) - i % 8;
			#12;
			if (i < 16)
				hd_q = lsb ? ins[i] : ins[15 - i];
			else if (ins[15])
				hd_q = ~hd_q;
			else
				hd_q = wd[x];
			#12 sclk = 1'b1;
			if (i >= 16)
				rd[x] = sdio_i;
			#24 sclk = 1'b0;
		end
		#24 cs_n = 1'b1;
		hd_q = ~hd_q;
		#100;
	endtask
endmodule // scpt_host

// *** test/scpt_port_chk.sv ***
`timescale 1ns/100ps
module scpt_port_chk (
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdio_i,
	input wire logic sdio_o,
	input wire logic sdio_oe_n,
	input wire logic lsb_first,
	input wire logic [7:0] pump_current,
	input wire logic soft_reset_pulse,
	input wire logic busy
);
	logic [7:0] cnt_q;
	logic first_q;
	logic last_q;
	// rising sclk edges seen in this frame, saturating
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n)
			cnt_q <= 8'h00;
		else
			cnt_q <= cnt_q + {7'h00, cnt_q != 8'hff};
	end
	// first and last instruction bits; which is the read flag depends on order
	always_ff @(posedge sclk) begin
		if (cnt_q == 8'h00)
			first_q <= sdio_i;
		if (cnt_q == 8'h0f)
			last_q <= sdio_i;
	end
	sequence s_srst_done;
		!soft_reset_pulse ##[0:2] (pump_current == 8'h80 && !lsb_first);
	endsequence
	a_pin_idle_off: assert property (@(posedge clk) disable iff (!resetn)
		cs_n && $past(cs_n) |-> sdio_oe_n) else $error("data pin driven while deselected");
	a_reset_values: assert property (@(posedge clk) disable iff (!resetn)
		$rose(resetn) |-> pump_current == 8'h80 && !lsb_first && !soft_reset_pulse)
		else $error("reset values wrong");
	a_srst_restores: assert property (@(posedge clk) disable iff (!resetn)
		soft_reset_pulse |=> s_srst_done) else $error("soft reset did not restore");
	a_busy_follows_select: assert property (@(posedge clk) disable iff (!resetn)
		$fell(cs_n) |-> ##[1:4] busy) else $error("busy late");
	a_data_on_fall: assert property (@(posedge clk) disable iff (!resetn)
		!sdio_oe_n && $past(!sdio_oe_n) && $changed(sdio_o) |-> !sclk)
		else $error("read data moved while sclk high");
	a_instr_quiet: assert property (@(posedge sclk) disable iff (cs_n)
		cnt_q < 8'h10 |-> sdio_oe_n) else $error("pin driven during instruction");
	a_read_drive_on: assert property (@(posedge sclk) disable iff (cs_n)
		cnt_q == 8'h10 |-> sdio_oe_n == !(lsb_first ? last_q : first_q))
		else $error("read drive does not match flag");
	a_read_drive_holds: assert property (@(posedge sclk) disable iff (cs_n)
		cnt_q > 8'h10 && !$past(sdio_oe_n) |-> !sdio_oe_n) else $error("read drive dropped");
endmodule // scpt_port_chk
bind scpt_port scpt_port_chk chk_u (.clk(clk), .resetn(resetn), .clk_en(clk_en),
	.sclk(sclk), .cs_n(cs_n), .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe_n(sdio_oe_n),
	.lsb_first(lsb_first), .pump_current(pump_current),
	.soft_reset_pulse(soft_reset_pulse), .busy(busy));

// *** test/scpt_port_tb.sv ***
`timescale 1ns/100ps
module scpt_port_tb;
	import scpt_pkg::*;
	logic clk, resetn, clk_en, sclk, cs_n, sdio_i, sdio_o, sdio_oe_n;
	logic lsb_first, soft_reset_pulse, busy;
	logic [7:0] pump_current;
	logic [31:0] rd;
	bit mode_lsb;
	int n_mismatch = 0;
	int n_tests = 0;
	scpt_port dut_u (.clk(clk), .resetn(resetn), .clk_en(clk_en), .sclk(sclk),
		.cs_n(cs_n), .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe_n(sdio_oe_n),
		.lsb_first(lsb_first), .pump_current(pump_current),
		.soft_reset_pulse(soft_reset_pulse), .busy(busy));
	scpt_host host_u (.sclk(sclk), .cs_n(cs_n), .sdio_i(sdio_i), .sdio_o(sdio_o),
		.sdio_oe_n(sdio_oe_n));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [15:0] ins, input logic [31:0] wd, input int n);
		host_u.xfer(ins, wd, n, mode_lsb, rd);
	endtask
	task automatic rdc(input string nm, input logic [15:0] ins, input int n,
		input logic [31:0] exp);
		host_u.xfer(ins, 32'h0000_0000, n, mode_lsb, rd);
		chk(nm, exp, rd);
	endtask
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		n_mismatch++;
		stop_test();
	end
	initial begin
		resetn = 1'b0;
		clk_en = 1'b1;
		mode_lsb = 1'b0;
		repeat (6) @(negedge clk);
		resetn = 1'b1;
		repeat (4) @(negedge clk);
		chk("outputs", 32'h0000_0080, {lsb_first, soft_reset_pulse, pump_current});
		rdc("cfg", 16'h8000, 1, 32'h1800_0000);
		rdc("len2", 16'hA001, 2, 32'h0018_0000);
		rdc("len3", 16'hC00B, 3, 32'h0080_0000);
		$display("reset and read lengths done");
		wr(16'h000A, 32'h5A00_0000, 1);
		wr(16'h0004, 32'h0100_0000, 1);
		rdc("active", 16'h800A, 1, 32'h8000_0000);
		wr(16'h0005, 32'h0100_0000, 1);
		chk("pump", 32'h0000_005A, {24'h00_0000, pump_current});
		wr(16'h000A, 32'h3300_0000, 1);
		rdc("stream", 16'hE00A, 4, 32'h3300_0000);
		rdc("aclr", 16'hC005, 3, 32'h0001_0000);
		chk("held", 32'h0000_005A, {24'h00_0000, pump_current});
		$display("buffering done");
		wr(16'h0000, 32'h4000_0000, 1);
		wr(16'h0005, 32'h0100_0000, 1);
		mode_lsb = 1'b1;
		chk("order", 32'h0000_0133, {23'h00_0000, lsb_first, pump_current});
		rdc("lsbrd", 16'hA004, 2, 32'h0100_0000);
		wr(16'h2009, 32'h0077_0000, 2);
		wr(16'h0005, 32'h0100_0000, 1);
		chk("lsbwr", 32'h0000_0077, {24'h00_0000, pump_current});
		rdc("cfglsb", 16'h8000, 1, 32'h5800_0000);
		$display("lsb first done");
		wr(16'h0000, 32'h6000_0000, 1);
		wr(16'h0005, 32'h0100_0000, 1);
		mode_lsb = 1'b0;
		chk("srst", 32'h0000_0080, {23'h00_0000, lsb_first, pump_current});
		rdc("srstcfg", 16'h8000, 1, 32'h1800_0000);
		$display("soft reset done");
		stop_test();
	end
endmodule // scpt_port_tb
